// ### logic/pcdc_pkg.sv
// shared constants for the modulator control block
package pcdc_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [7:0] IDX_MODULATOR_CONTROL = 8'h89;
  localparam logic [7:0] IDX_OPTION_SELECT_TWO = 8'h91;
  localparam logic [7:0] IDX_PERIOD_UPPER_BYTE = 8'h92;
  localparam logic [7:0] IDX_MODULATOR_STATUS = 8'hf0;
  localparam logic [7:0] IDX_COUNT_LOW = 8'hf1;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'hf2;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTL_GATE_BIT = 7;
  localparam int CTL_STYLE_LSB = 4;
  localparam int CTL_STYLE_W = 2;
  localparam int CTL_WIDTH_LSB = 0;
  localparam int CTL_WIDTH_W = 4;
  localparam int OPT_SRC_LSB = 4;
  localparam int OPT_SRC_W = 2;
  localparam int STS_RUN_BIT = 0;
  localparam int STS_RAW_BIT = 1;
  localparam int STS_GAP_BIT = 2;
  localparam int STS_OUTA_BIT = 3;
  localparam int STS_OUTB_BIT = 4;

  // ****************************************
  // reset values and masks
  // ****************************************
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [7:0] CTL_MASK = 8'hbf;
  localparam logic [7:0] OPT_RESET = 8'h00;
  localparam logic [7:0] OPT_MASK = 8'h30;
  localparam logic [7:0] PRD_HI_RESET = 8'hff;

  // ****************************************
  // ahb encodings
  // ****************************************
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // ****************************************
  // clock source and output style codes
  // ****************************************
  typedef enum logic [1:0] {
    SRC_SYS0 = 2'b00,
    SRC_SYS1 = 2'b01,
    SRC_FAST = 2'b10,
    SRC_FAST_X2 = 2'b11
  } pcdc_src_t;

  typedef enum logic [1:0] {
    STYLE_COMPL = 2'b00,
    STYLE_COMPL_INV = 2'b01,
    STYLE_SAME = 2'b10,
    STYLE_SINGLE = 2'b11
  } pcdc_style_t;

endpackage : pcdc_pkg

// ### logic/pcdc_top.sv
// modulator channel-0 control: clock gate, source select, non-overlap and period
module pcdc_top #(
  parameter int COUNT_W = 16,
  parameter int GAP_W = 4
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // clock source ticks, synchronous one-cycle strobes
  input wire logic fast_osc_tick,
  input wire logic fast_osc_x2_tick,
  // compare values from the neighbouring registers
  input wire logic [7:0] period_lower_byte,
  input wire logic [COUNT_W-1:0] channel0_duty,
  // output pins
  output logic channel0_out_a,
  output logic channel0_out_b
);

  // ****************************************
  // elaboration checks
  // ****************************************
  if (COUNT_W != 16) begin : g_bad_count
    $error("pcdc_top: period is two bytes wide, COUNT_W must be 16");
  end
  // a narrower gap counter could not hold the largest width code
  if (GAP_W < pcdc_pkg::CTL_WIDTH_W || GAP_W > 8) begin : g_bad_gap
    $error("pcdc_top: GAP_W must be 4 to 8");
  end

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic ahb_take(input logic sel, input logic [1:0] trans,
                                    input logic rdy);
    ahb_take = sel && rdy && (trans == pcdc_pkg::HTRANS_NONSEQ ||
                              trans == pcdc_pkg::HTRANS_SEQ);
  endfunction : ahb_take

  function automatic logic [7:0] word_index(input logic [31:0] addr);
    word_index = addr[9:2];
  endfunction : word_index

  // bits software may change in each register; zero marks a read-only or unmapped index
  function automatic logic [7:0] write_mask(input logic [7:0] idx);
    unique case (idx)
      pcdc_pkg::IDX_MODULATOR_CONTROL: write_mask = pcdc_pkg::CTL_MASK;
      pcdc_pkg::IDX_OPTION_SELECT_TWO: write_mask = pcdc_pkg::OPT_MASK;
      pcdc_pkg::IDX_PERIOD_UPPER_BYTE: write_mask = 8'hff;
      default: write_mask = 8'h00;
    endcase
  endfunction : write_mask

  // ****************************************
  // registers
  // ****************************************
  logic [7:0] modulator_control_reg;
  logic [7:0] option_select_two_reg;
  logic [7:0] period_upper_byte_reg;
  logic wr_pend_reg;
  logic [7:0] wr_idx_reg;
  logic [COUNT_W-1:0] count_reg;
  logic raw_reg;
  logic [GAP_W-1:0] gap_cnt_reg;
  logic gap_reg;

  logic modulator_clock_gate;
  pcdc_pkg::pcdc_style_t channel0_output_style;
  logic [GAP_W-1:0] channel0_nonoverlap_width;
  pcdc_pkg::pcdc_src_t modulator_clock_source;
  logic [COUNT_W-1:0] period_value;
  logic mod_tick;
  logic raw_next;
  logic [7:0] status_value;
  logic [7:0] read_value;
  logic [7:0] fwd_value;

  assign modulator_clock_gate = modulator_control_reg[pcdc_pkg::CTL_GATE_BIT];
  assign channel0_output_style = pcdc_pkg::pcdc_style_t'(
    modulator_control_reg[pcdc_pkg::CTL_STYLE_LSB +: pcdc_pkg::CTL_STYLE_W]);
  assign channel0_nonoverlap_width =
    GAP_W'(modulator_control_reg[pcdc_pkg::CTL_WIDTH_LSB +: pcdc_pkg::CTL_WIDTH_W]);
  assign modulator_clock_source = pcdc_pkg::pcdc_src_t'(
    option_select_two_reg[pcdc_pkg::OPT_SRC_LSB +: pcdc_pkg::OPT_SRC_W]);
  assign period_value = {period_upper_byte_reg, period_lower_byte};

  // ****************************************
  // bus slave: zero wait states, always okay
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // write address captured in the address phase, data landed in the data phase
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 8'h00;
    end else if (ce) begin
      wr_pend_reg <= ahb_take(hsel, htrans, hready) && hwrite &&
                     hsize == pcdc_pkg::HSIZE_WORD;
      wr_idx_reg <= word_index(haddr);
    end
  end

  always_comb begin
    status_value = 8'h00;
    status_value[pcdc_pkg::STS_RUN_BIT] = modulator_clock_gate;
    status_value[pcdc_pkg::STS_RAW_BIT] = raw_reg;
    status_value[pcdc_pkg::STS_GAP_BIT] = gap_reg;
    status_value[pcdc_pkg::STS_OUTA_BIT] = channel0_out_a;
    status_value[pcdc_pkg::STS_OUTB_BIT] = channel0_out_b;
  end

  // status and count views are read-only; writes to their indices are dropped
  always_comb begin
    unique case (word_index(haddr))
      pcdc_pkg::IDX_MODULATOR_CONTROL: read_value = modulator_control_reg;
      pcdc_pkg::IDX_OPTION_SELECT_TWO: read_value = option_select_two_reg;
      pcdc_pkg::IDX_PERIOD_UPPER_BYTE: read_value = period_upper_byte_reg;
      pcdc_pkg::IDX_MODULATOR_STATUS: read_value = status_value;
      pcdc_pkg::IDX_COUNT_LOW: read_value = count_reg[7:0];
      pcdc_pkg::IDX_COUNT_HIGH: read_value = count_reg[15:8];
      default: read_value = 8'h00;
    endcase
  end

  // a read taken while a write to the same register is still in its data phase
  // sees the new byte, since the register itself lands only at the next edge
  always_comb begin
    fwd_value = read_value;
    if (wr_pend_reg && wr_idx_reg == word_index(haddr) &&
        write_mask(wr_idx_reg) != 8'h00) begin
      fwd_value = hwdata[7:0] & write_mask(wr_idx_reg);
    end
  end

  // read data set up at the address-phase edge, so it stands for the data phase
  always_ff @(posedge clk) begin
    if (srst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && ahb_take(hsel, htrans, hready) && !hwrite) begin
      hrdata <= {24'h00_0000, fwd_value};
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (srst) begin
      modulator_control_reg <= pcdc_pkg::CTL_RESET;
    end else if (ce && wr_pend_reg && wr_idx_reg == pcdc_pkg::IDX_MODULATOR_CONTROL) begin
      modulator_control_reg <= hwdata[7:0] & pcdc_pkg::CTL_MASK;
    end
  end

  // only the source field is kept; the other bits of this byte live elsewhere
  always_ff @(posedge clk) begin
    if (srst) begin
      option_select_two_reg <= pcdc_pkg::OPT_RESET;
    end else if (ce && wr_pend_reg && wr_idx_reg == pcdc_pkg::IDX_OPTION_SELECT_TWO) begin
      option_select_two_reg <= hwdata[7:0] & pcdc_pkg::OPT_MASK;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      period_upper_byte_reg <= pcdc_pkg::PRD_HI_RESET;
    end else if (ce && wr_pend_reg && wr_idx_reg == pcdc_pkg::IDX_PERIOD_UPPER_BYTE) begin
      period_upper_byte_reg <= hwdata[7:0];
    end
  end

  // ****************************************
  // modulator clock: source select and gate
  // ****************************************
  // oscillators arrive as strobes in the system domain; a real doubled clock
  // would need its own domain, traded here for a single-clock design
  // both 0x codes pick the system clock, so it ticks on every cycle
  always_comb begin
    unique case (modulator_clock_source)
      pcdc_pkg::SRC_SYS0, pcdc_pkg::SRC_SYS1: mod_tick = 1'b1;
      pcdc_pkg::SRC_FAST: mod_tick = fast_osc_tick;
      pcdc_pkg::SRC_FAST_X2: mod_tick = fast_osc_x2_tick;
    endcase
  end

  // ****************************************
  // period counter and raw compare
  // ****************************************
  // the counter holds while the gate is off, so software can read where it stopped
  always_ff @(posedge clk) begin
    if (srst) begin
      count_reg <= '0;
    end else if (ce && modulator_clock_gate && mod_tick) begin
      count_reg <= (count_reg >= period_value) ? '0 : count_reg + 1'b1;
    end
  end

  assign raw_next = (count_reg < channel0_duty);

  // ****************************************
  // non-overlap gap
  // ****************************************
  // in the complementary styles each edge of the raw wave holds both outputs inactive for the width count
  always_ff @(posedge clk) begin
    if (srst) begin
      raw_reg <= 1'b0;
      gap_cnt_reg <= '0;
      gap_reg <= 1'b0;
    end else if (ce) begin
      if (!modulator_clock_gate) begin
        raw_reg <= 1'b0;
        gap_cnt_reg <= '0;
        gap_reg <= 1'b0;
      end else if (channel0_nonoverlap_width == '0) begin
        // a zero width ends a running gap at once instead of letting it run out
        gap_cnt_reg <= '0;
        gap_reg <= 1'b0;
        if (mod_tick) begin
          raw_reg <= raw_next;
        end
      end else if (mod_tick) begin
        raw_reg <= raw_next;
        if (raw_next != raw_reg && channel0_nonoverlap_width != '0) begin
          gap_cnt_reg <= channel0_nonoverlap_width;
          gap_reg <= 1'b1;
        end else if (gap_cnt_reg > GAP_W'(1)) begin
          gap_cnt_reg <= gap_cnt_reg - 1'b1;
        end else begin
          gap_cnt_reg <= '0;
          gap_reg <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // output styles
  // ****************************************
  // gate off forces both pins low rather than freezing them, so a stopped
  // modulator leaves no switch turned on, except in the inverted style where low is active
  // gap check uses the registered flag, so the first gap cycle starts with
  // the raw change and lasts exactly the programmed count of ticks
  always_ff @(posedge clk) begin
    if (srst) begin
      channel0_out_a <= 1'b0;
      channel0_out_b <= 1'b0;
    end else if (ce) begin
      if (!modulator_clock_gate) begin
        channel0_out_a <= 1'b0;
        channel0_out_b <= 1'b0;
      end else begin
        unique case (channel0_output_style)
          pcdc_pkg::STYLE_COMPL: begin
            channel0_out_a <= raw_reg && !gap_reg;
            channel0_out_b <= !raw_reg && !gap_reg;
          end
          pcdc_pkg::STYLE_COMPL_INV: begin
            channel0_out_a <= !(raw_reg && !gap_reg);
            channel0_out_b <= !(!raw_reg && !gap_reg);
          end
          pcdc_pkg::STYLE_SAME: begin
            channel0_out_a <= raw_reg;
            channel0_out_b <= raw_reg;
          end
          pcdc_pkg::STYLE_SINGLE: begin
            channel0_out_a <= raw_reg;
            channel0_out_b <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule : pcdc_top

// ### tb/pcdc_asserts.sv
// checker for the modulator control block, bound to its top
module pcdc_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  // bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // pins
  input wire logic channel0_out_a,
  input wire logic channel0_out_b
);
  timeunit 1ns;
  timeprecision 1ps;
  // *****
  // shadow of written registers
  // *****
  logic wr_q, rd_q;
  logic [7:0] ad_q, ctl, prd;
  wire tk = ce && hsel && hready && htrans[1];
  always_ff @(posedge clk) begin
    if (ce) begin
      wr_q <= !srst && tk && hwrite && hsize == pcdc_pkg::HSIZE_WORD;
      rd_q <= !srst && tk && !hwrite;
      ad_q <= haddr[9:2];
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      ctl <= 8'h00;
      prd <= 8'hff;
    end else if (ce && wr_q) begin
      if (ad_q == pcdc_pkg::IDX_MODULATOR_CONTROL) ctl <= hwdata[7:0] & pcdc_pkg::CTL_MASK;
      if (ad_q == pcdc_pkg::IDX_PERIOD_UPPER_BYTE) prd <= hwdata[7:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // *****
  // properties
  // *****
  property p_gate_off; !ctl[7] [*3] |-> !channel0_out_a && !channel0_out_b; endproperty
  property p_wake; $fell(srst) |-> !channel0_out_a && !channel0_out_b; endproperty
  property p_no_overlap; ctl[5:4] == 2'h0 [*3] |-> !(channel0_out_a && channel0_out_b);
  endproperty
  property p_zero_gap; (ctl[7] && ctl[5:0] == 6'h00) [*4] |-> channel0_out_a != channel0_out_b;
  endproperty
  property p_single; (ctl[7] && ctl[5:4] == 2'h3) [*4] |-> !channel0_out_b; endproperty
  property p_same; (ctl[7] && ctl[5:4] == 2'h2) [*4] |-> channel0_out_a == channel0_out_b;
  endproperty
  property p_ctl_read; rd_q && ad_q == pcdc_pkg::IDX_MODULATOR_CONTROL |-> hrdata == {24'h0, ctl};
  endproperty
  property p_prd_read; rd_q && ad_q == pcdc_pkg::IDX_PERIOD_UPPER_BYTE |-> hrdata == {24'h0, prd};
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("outputs active with gate off");
  a_wake: assert property (p_wake)
    else $error("outputs active after reset");
  a_no_overlap: assert property (p_no_overlap)
    else $error("both outputs high");
  a_zero_gap: assert property (p_zero_gap)
    else $error("gap seen with zero width");
  a_single: assert property (p_single)
    else $error("secondary active in single mode");
  a_same: assert property (p_same)
    else $error("outputs differ in same mode");
  a_ctl_read: assert property (p_ctl_read)
    else $error("control read mismatch");
  a_prd_read: assert property (p_prd_read)
    else $error("period read mismatch");
  c_gate_on: cover property (ctl[7] && channel0_out_a);
  c_single: cover property (ctl[5:4] == 2'h3 && channel0_out_a);
  c_gap: cover property ($fell(channel0_out_a) ##1 !channel0_out_b);
endmodule : pcdc_asserts

// ### tb/pcdc_load.sv
// load on the output pins: counts pulses driven into the primary switch
module pcdc_load (
  // pins
  input wire logic clk,
  input wire logic channel0_out_a,
  input wire logic channel0_out_b,
  // observation
  output int pulses
);
  timeunit 1ns;
  timeprecision 1ps;
  logic a_q = 1'b0;
  initial pulses = 0;
  always @(posedge clk) begin
    a_q <= channel0_out_a;
    if (channel0_out_a && !a_q) pulses <= pulses + 1;
  end
endmodule : pcdc_load

// ### tb/testbench.sv
// self-checking bench for the modulator control block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [2:0] W = pcdc_pkg::HSIZE_WORD;
  localparam logic [7:0] CTL = pcdc_pkg::IDX_MODULATOR_CONTROL;
  localparam logic [7:0] OPT = pcdc_pkg::IDX_OPTION_SELECT_TWO;
  localparam logic [7:0] PRD = pcdc_pkg::IDX_PERIOD_UPPER_BYTE;
  logic clk = 1'b0, srst = 1'b1, hwrite = 1'b0, tick_f = 1'b0, tick_x2 = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0;
  logic [15:0] duty = 16'h0, seed = 16'h46be;
  logic [7:0] regs [4] = '{CTL, OPT, PRD, 8'hff};
  wire hreadyout, hresp, out_a, out_b;
  wire [31:0] hrdata;
  int miscompares = 0, checked = 0, cyc = 0, pulses;
  int dv [4] = '{1, 1, 4, 2};
  int gw [3] = '{0, 1, 15};
  int mdl [int];
  pcdc_top dut_u (.clk(clk), .srst(srst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fast_osc_tick(tick_f),
    .fast_osc_x2_tick(tick_x2), .period_lower_byte(8'h27), .channel0_duty(duty),
    .channel0_out_a(out_a), .channel0_out_b(out_b));
  pcdc_load load_u (.clk(clk), .channel0_out_a(out_a), .channel0_out_b(out_b), .pulses(pulses));
  initial forever #2.5 clk = ~clk;
  // oscillator strobes every fourth and every second cycle: the doubled one is twice as fast
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tick_f <= (cyc % 4 == 0);
    tick_x2 <= (cyc % 2 == 0);
  end
  // *****
  // helpers
  // *****
  task automatic report_and_stop();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : report_and_stop
  task automatic lost();
    miscompares++;
    report_and_stop();
  endtask : lost
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  function automatic logic [7:0] msk(input logic [7:0] idx);
    return idx == CTL ? pcdc_pkg::CTL_MASK : idx == OPT ? pcdc_pkg::OPT_MASK : 8'hff;
  endfunction : msk
  task automatic bus(input logic w, input logic [2:0] sz, input logic [7:0] idx,
      input logic [31:0] d, output logic [31:0] r);
    int n;
    htrans <= pcdc_pkg::HTRANS_NONSEQ;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= w;
    hsize <= sz;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 99);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 99);
    if (n >= 99) lost();
    r = hrdata;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [2:0] sz);
    logic [31:0] r;
    bus(1'b1, sz, idx, {24'h0, v}, r);
    if (sz == W && mdl.exists(idx)) mdl[idx] = v & msk(idx);
  endtask : wr
  // write then read of one register back to back: the read address phase
  // overlaps the write data phase, so the read must already see the new byte
  task automatic wr_rd(input logic [7:0] idx, input logic [7:0] v);
    int n;
    htrans <= pcdc_pkg::HTRANS_NONSEQ;
    haddr <= {22'h0, idx, 2'h0};
    hwrite <= 1'b1;
    hsize <= W;
    n = 0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 99);
    hwrite <= 1'b0;
    hwdata <= {24'h0, v};
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 99);
    htrans <= 2'h0;
    do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 99);
    if (n >= 99) lost();
    if (mdl.exists(idx)) mdl[idx] = v & msk(idx);
    chk(hrdata, mdl.exists(idx) ? mdl[idx] : 0);
  endtask : wr_rd
  task automatic rd_chk(input logic [7:0] idx);
    logic [31:0] r;
    bus(1'b0, W, idx, 32'h0, r);
    chk(r, mdl.exists(idx) ? mdl[idx] : 0);
  endtask : rd_chk
  task automatic ws(input bit sb, input logic v, output int n);
    n = 0;
    while ((sb ? out_b : out_a) !== v) begin
      @(posedge clk);
      n++;
      if (n > 999) lost();
    end
  endtask : ws
  task automatic measure(output int hi, output int per);
    int n;
    ws(0, 1'b0, n);
    ws(0, 1'b1, n);
    ws(0, 1'b0, hi);
    ws(0, 1'b1, per);
    per += hi;
  endtask : measure
  // *****
  // main sequence
  // *****
  initial begin
    int hi, per, n;
    logic [31:0] r, r2;
    mdl[CTL] = 8'h00;
    mdl[OPT] = 8'h00;
    mdl[PRD] = 8'hff;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(regs[i]);
    wr(CTL, 8'hff, W);
    wr(OPT, 8'hff, W);
    wr(PRD, 8'h00, W);
    wr(PRD, 8'h5a, 3'h0);
    wr(8'hff, 8'h12, W);
    for (int i = 0; i < 4; i++) rd_chk(regs[i]);
    wr_rd(OPT, 8'h2f);
    // period is 0x0027 + 1 = 40 ticks
    for (int s = 0; s < 4; s++) begin
      seed = lfsr(seed);
      duty <= seed % 16'h27 + 16'h1;
      wr(OPT, 8'(s << 4), W);
      wr(CTL, 8'h80, W);
      measure(hi, per);
      measure(hi, per);
      chk(per, 40 * dv[s]);
      chk(hi, duty * dv[s]);
    end
    // styles at a fixed duty of 12 of 40 ticks: the inverted style shows 28 high
    wr(OPT, 8'h00, W);
    duty <= 16'h0c;
    for (int st = 1; st < 4; st++) begin
      wr(CTL, 8'(32'h80 | st << 4), W);
      measure(hi, per);
      measure(hi, per);
      chk(per, 40);
      chk(hi, st == 1 ? 28 : 12);
    end
    duty <= 16'h14;
    for (int i = 0; i < 3; i++) begin
      wr(CTL, 8'(32'h80 | gw[i]), W);
      measure(hi, per);
      ws(0, 1'b0, n);
      ws(1, 1'b1, n);
      chk(n, gw[i]);
    end
    wr(CTL, 8'h00, W);
    repeat (5) @(posedge clk);
    chk({out_a, out_b}, 2'h0);
    bus(1'b0, W, pcdc_pkg::IDX_MODULATOR_STATUS, 32'h0, r);
    chk(r, 32'h0);
    bus(1'b0, W, pcdc_pkg::IDX_COUNT_LOW, 32'h0, r);
    repeat (10) @(posedge clk);
    bus(1'b0, W, pcdc_pkg::IDX_COUNT_LOW, 32'h0, r2);
    chk(r2, r);
    chk(32'(pulses != 0), 32'h1);
    report_and_stop();
  end
endmodule : testbench
bind pcdc_top pcdc_asserts chk_u (.clk(clk), .srst(srst), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .channel0_out_a(channel0_out_a), .channel0_out_b(channel0_out_b));
